// ### common/meter_defs.svh
`ifndef METER_DEFS_SVH
`define METER_DEFS_SVH
// Notes on behaviour
// - Scale and two frequency selects pick one of five distinct base frequencies.
// - Energy pulses alternate between the two low-frequency outputs, active high.
// - Low-frequency pulse high time is 120 ms when the period allows.
// - Second output rises about half a period after the first output.
// - Below 550 ms period, low-frequency high time becomes half the period.
// - Calibration output gives 90 ms high pulses at rate proportional to power.
// - Below 190 ms calibration period, high time becomes half the period.
// - No pulse on any output while load is below the minimum frequency.
// - No-load threshold is checked on the summed power of all phases.
// - Minimum frequency is 0.0075 percent of full-scale output frequency.
// - Minimum pulse frequency follows the select code.
// - Reverse flag high for negative summed power, low for positive.
// - Reverse flag changes only when a calibration pulse is issued.
// - Reverse flag stays high until summed power is measured positive again.
// - Calibration rate is a code-dependent multiple of the low-frequency rate.
// - Both outputs derive from filtered power; calibration averages over less time.

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_CYC_PER_MS     100000
`define LF_WIDTH_MS        120
`define LF_FALLBACK_MS     550
`define CF_WIDTH_MS        90
`define CF_FALLBACK_MS     190

// ------------------------------------------------------------
// No-load threshold, parts per million of full scale
// ------------------------------------------------------------
`define CREEP_PPM          75
`define PPM_DIV            1000000

// ------------------------------------------------------------
// Base frequency per code, hundredths of a hertz
// ------------------------------------------------------------
`define BASE_CHZ_0         10'd230
`define BASE_CHZ_1         10'd461
`define BASE_CHZ_2         10'd115
`define BASE_CHZ_3         10'd461
`define BASE_CHZ_4         10'd522
`define BASE_CHZ_5         10'd115
`define BASE_CHZ_6         10'd58
`define BASE_CHZ_7         10'd58

// ------------------------------------------------------------
// Calibration to low-frequency pulse ratio per code
// ------------------------------------------------------------
`define CF_RATIO_0         8'd16
`define CF_RATIO_1         8'd8
`define CF_RATIO_2         8'd32
`define CF_RATIO_3         8'd16
`define CF_RATIO_4         8'd160
`define CF_RATIO_5         8'd16
`define CF_RATIO_6         8'd32
`define CF_RATIO_7         8'd16
`endif

// ### common/meter_pkg.sv
package meter_pkg;
  typedef logic [2:0] sel_code_t;
  typedef logic [9:0] base_chz_t;
  typedef logic [7:0] cf_ratio_t;
  typedef enum logic {SHAPE_IDLE, SHAPE_HIGH} shape_state_t;
endpackage

// ### common/pulse_if.sv
`timescale 1ns/1ps
interface pulse_if;
  logic fire;
  logic level;
  modport source (output fire, input level);
  modport shaper (input fire, output level);
endinterface

// ### tb/energy_pulse_output_assertions.sv
`timescale 1ns/1ps
module energy_pulse_output_assertions #(
  parameter int PWR_W        = 24,
  parameter int LF_WIDTH_CYC = 12,
  parameter int LF_LIMIT_CYC = 55
) (
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic signed [PWR_W-1:0] power_sample,
  input wire logic                    power_valid,
  input wire logic                    energy_pulse_a,
  input wire logic                    energy_pulse_b,
  input wire logic                    calibration_pulse,
  input wire logic                    reverse_power_flag
);
  localparam longint CREEP_THR = ((longint'(1) <<< (PWR_W - 1)) * 75) / 1000000;
  logic        big;
  logic        last_a_q;
  logic [31:0] len_a_q;
  logic [31:0] gap_a_q;
  logic [31:0] per_a_q;
  logic [31:0] want_a;
  longint      mag;
  assign mag = (power_sample < 0) ? -longint'(power_sample) : longint'(power_sample);
  assign big = power_valid && (mag >= CREEP_THR);
  // Short periods fall back to half the period, which may exceed the fixed width
  assign want_a = (per_a_q < LF_LIMIT_CYC) ? ((per_a_q > 32'h1) ? (per_a_q >> 1) : 32'h1) : 32'(LF_WIDTH_CYC);
  // Tracks which slow output fired last; reset means b, so a leads
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_a_q <= 1'b0;
      len_a_q  <= '0;
      gap_a_q  <= '1;
      per_a_q  <= '1;
    end else begin
      if ($rose(energy_pulse_a)) last_a_q <= 1'b1;
      else if ($rose(energy_pulse_b)) last_a_q <= 1'b0;
      len_a_q <= energy_pulse_a ? len_a_q + 32'h1 : 32'h0;
      // Rise-to-rise spacing of a; saturates so the first pulse reads as slow
      gap_a_q <= $rose(energy_pulse_a) ? 32'h1 : ((gap_a_q == '1) ? gap_a_q : gap_a_q + 32'h1);
      if ($rose(energy_pulse_a)) per_a_q <= gap_a_q;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_cf_cause; $rose(calibration_pulse) |-> $past(big); endproperty
  a_cf_cause: assert property (p_cf_cause)
    else $error("calibration pulse without accepted sample");
  property p_rev_with_cf; $changed(reverse_power_flag) |-> calibration_pulse; endproperty
  a_rev_with_cf: assert property (p_rev_with_cf)
    else $error("reverse flag moved without calibration pulse");
  property p_rev_set; $rose(reverse_power_flag) |-> $past(big && power_sample < 0); endproperty
  a_rev_set: assert property (p_rev_set)
    else $error("reverse flag set without negative sample");
  property p_rev_clear; $fell(reverse_power_flag) |-> $past(big && power_sample > 0); endproperty
  a_rev_clear: assert property (p_rev_clear)
    else $error("reverse flag cleared without positive sample");
  property p_lf_alt;
    ($rose(energy_pulse_a) |-> !last_a_q) and ($rose(energy_pulse_b) |-> last_a_q);
  endproperty
  a_lf_alt: assert property (p_lf_alt)
    else $error("slow pulses not alternating");
  property p_lf_width;
    (len_a_q <= want_a) and ($fell(energy_pulse_a) |-> len_a_q == want_a);
  endproperty
  a_lf_width: assert property (p_lf_width)
    else $error("slow pulse width wrong");
  property p_lf_with_cf; ($rose(energy_pulse_a) || $rose(energy_pulse_b)) |-> calibration_pulse; endproperty
  a_lf_with_cf: assert property (p_lf_with_cf)
    else $error("slow pulse without calibration pulse");
  property p_reset_quiet;
    $rose(resetn) |-> !(energy_pulse_a || energy_pulse_b || calibration_pulse || reverse_power_flag);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output active at reset release");
  c_pulse_b: cover property ($rose(energy_pulse_b));
  c_rev_set: cover property ($rose(reverse_power_flag));
  c_rev_clear: cover property ($fell(reverse_power_flag));
endmodule

bind energy_pulse_output energy_pulse_output_assertions #(.PWR_W(PWR_W), .LF_WIDTH_CYC(LF_WIDTH_CYC),
  .LF_LIMIT_CYC(LF_LIMIT_CYC))
  energy_pulse_output_assertions_i (.clk(clk), .resetn(resetn), .power_sample(power_sample),
  .power_valid(power_valid), .energy_pulse_a(energy_pulse_a), .energy_pulse_b(energy_pulse_b),
  .calibration_pulse(calibration_pulse), .reverse_power_flag(reverse_power_flag));

// ### tb/energy_pulse_output_test.sv
`timescale 1ns/1ps
module energy_pulse_output_test;
  import meter_pkg::*;
  // Quantum equal to the P0 and P1 increments, so each such sample fires once
  localparam longint QNT = 64'h40b7_3000;
  localparam longint P0  = 295040;
  localparam longint P1  = 294400;
  typedef struct packed {sel_code_t code; logic neg;} row_t;
  row_t        rows [8] = '{'{3'h0, 1'b0}, '{3'h1, 1'b1}, '{3'h2, 1'b0}, '{3'h3, 1'b1},
                            '{3'h4, 1'b0}, '{3'h5, 1'b1}, '{3'h6, 1'b0}, '{3'h7, 1'b1}};
  int          base [8] = '{230, 461, 115, 461, 522, 115, 58, 58};
  int          ratio [8] = '{16, 8, 32, 16, 160, 16, 32, 16};
  logic        clk, resetn, power_valid, calib_scale_select, freq_select_hi, freq_select_lo;
  logic signed [23:0] power_sample;
  logic        pa, pb, pcf, rev;
  logic [15:0] cnt_a, cnt_b, cnt_cf, len_a, len_cf, gap_ab;
  int          err_total, tests_run, cf_e;
  longint      acc, inc, p;
  sel_code_t   c;

  energy_pulse_output #(.CF_QUANTUM(QNT[47:0]), .LF_WIDTH_CYC(12), .LF_LIMIT_CYC(55),
    .CF_WIDTH_CYC(9), .CF_LIMIT_CYC(19)) energy_pulse_output_i (.clk(clk), .resetn(resetn),
    .power_sample(power_sample), .power_valid(power_valid), .calib_scale_select(calib_scale_select),
    .freq_select_hi(freq_select_hi), .freq_select_lo(freq_select_lo), .energy_pulse_a(pa),
    .energy_pulse_b(pb), .calibration_pulse(pcf), .reverse_power_flag(rev));
  meter_counter meter_counter_i (.clk(clk), .resetn(resetn), .pulse_a(pa), .pulse_b(pb), .pulse_cf(pcf),
    .cnt_a(cnt_a), .cnt_b(cnt_b), .cnt_cf(cnt_cf), .len_a(len_a), .len_cf(len_cf), .gap_ab(gap_ab));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic rst(input sel_code_t code);
    resetn <= 1'b0;
    {calib_scale_select, freq_select_hi, freq_select_lo} <= code;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // Gap is at least 2 so valid never rises again in the step it fell
  task automatic send(input longint v, input int gap);
    power_valid <= 1'b1;
    power_sample <= v[23:0];
    @(posedge clk);
    power_valid <= 1'b0;
    repeat (gap - 1) @(posedge clk);
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    results;
  end

  initial begin
    {resetn, power_valid, calib_scale_select, freq_select_hi, freq_select_lo} = '0;
    power_sample = '0;
    err_total = 0;
    tests_run = 0;
    // ----------------------------------------
    // Per-code rate rows
    // ----------------------------------------
    foreach (rows[i]) begin
      rst(rows[i].code);
      check("reset outputs", {pa, pb, pcf, rev}, 4'h0);
      c = rows[i].code;
      p = (QNT * 3 / 5) / (base[c] * ratio[c]);
      inc = p * base[c] * ratio[c];
      acc = 0;
      cf_e = 0;
      for (int n = 0; n < 2000 && cf_e < 2 * ratio[c]; n++) begin
        send(rows[i].neg ? -p : p, 25);
        acc += inc;
        if (acc >= QNT) begin
          acc -= QNT;
          cf_e++;
        end
      end
      repeat (30) @(posedge clk);
      check("cf count", cnt_cf, cf_e);
      check("a count", cnt_a, 1);
      check("b count", cnt_b, 1);
      check("reverse flag", rev, rows[i].neg);
    end
    // ----------------------------------------
    // Creep threshold and reverse flag timing
    // ----------------------------------------
    rst(3'h0);
    send(P0, 25);
    check("cf first", cnt_cf, 1);
    for (int n = 0; n < 500; n++) send(-628, 2);
    send(-1000, 25);
    check("cf under creep", cnt_cf, 1);
    check("flag before fire", rev, 0);
    send(-P0, 25);
    check("flag on fire", rev, 1);
    for (int n = 0; n < 500; n++) send(628, 2);
    send(1000, 25);
    check("flag held", rev, 1);
    check("cf held", cnt_cf, 2);
    send(P0, 25);
    check("flag cleared", rev, 0);
    // ----------------------------------------
    // Width fallbacks
    // ----------------------------------------
    rst(3'h0);
    send(P0, 25);
    check("cf full width", len_cf, 9);
    for (int n = 0; n < 5; n++) send(P0, 10);
    repeat (10) @(posedge clk);
    check("cf half width", len_cf, 5);
    rst(3'h1);
    for (int n = 0; n < 64; n++) send(P1, 3);
    repeat (30) @(posedge clk);
    check("slow half width", len_a, 24);
    check("b after a", gap_ab, 24);
    check("slow count", cnt_a + cnt_b, 8);
    results;
  end
endmodule

// ### tb/meter_counter.sv
`timescale 1ns/1ps
module meter_counter (
  input wire logic         clk,
  input wire logic         resetn,
  input wire logic         pulse_a,
  input wire logic         pulse_b,
  input wire logic         pulse_cf,
  output logic      [15:0] cnt_a,
  output logic      [15:0] cnt_b,
  output logic      [15:0] cnt_cf,
  output logic      [15:0] len_a,
  output logic      [15:0] len_cf,
  output logic      [15:0] gap_ab
);
  logic [15:0] run_a, run_cf, since_a;
  logic        a_q, b_q, cf_q;
  // Counts rising edges like an impulse counter; also keeps last high time
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {cnt_a, cnt_b, cnt_cf, len_a, len_cf, gap_ab} <= '0;
      {run_a, run_cf, since_a, a_q, b_q, cf_q} <= '0;
    end else begin
      {a_q, b_q, cf_q} <= {pulse_a, pulse_b, pulse_cf};
      run_a <= pulse_a ? run_a + 16'h1 : 16'h0;
      run_cf <= pulse_cf ? run_cf + 16'h1 : 16'h0;
      since_a <= (pulse_a && !a_q) ? 16'h1 : since_a + 16'h1;
      if (pulse_a && !a_q) cnt_a <= cnt_a + 16'h1;
      if (pulse_b && !b_q) cnt_b <= cnt_b + 16'h1;
      if (pulse_b && !b_q) gap_ab <= since_a;
      if (pulse_cf && !cf_q) cnt_cf <= cnt_cf + 16'h1;
      if (!pulse_a && a_q) len_a <= run_a;
      if (!pulse_cf && cf_q) len_cf <= run_cf;
    end
  end
endmodule

// ### verilog/energy_pulse_output.sv
`timescale 1ns/1ps
`include "meter_defs.svh"
module energy_pulse_output
  import meter_pkg::*;
#(
  parameter int              PWR_W          = 24,
  parameter int              ACC_W          = 48,
  parameter int              CNT_W          = 28,
  parameter logic [47:0]     CF_QUANTUM     = 48'h0000_4000_0000,
  parameter int              LF_WIDTH_CYC   = `LF_WIDTH_MS * `CLK_CYC_PER_MS,
  parameter int              LF_LIMIT_CYC   = `LF_FALLBACK_MS * `CLK_CYC_PER_MS,
  parameter int              CF_WIDTH_CYC   = `CF_WIDTH_MS * `CLK_CYC_PER_MS,
  parameter int              CF_LIMIT_CYC   = `CF_FALLBACK_MS * `CLK_CYC_PER_MS
) (
  input  logic                    clk,
  input  logic                    resetn,
  input  logic signed [PWR_W-1:0] power_sample,
  input  logic                    power_valid,
  input  logic                    calib_scale_select,
  input  logic                    freq_select_hi,
  input  logic                    freq_select_lo,
  output logic                    energy_pulse_a,
  output logic                    energy_pulse_b,
  output logic                    calibration_pulse,
  output logic                    reverse_power_flag
);
  import meter_pkg::*;

  initial begin
    if (PWR_W < 8 || PWR_W > 32 || ACC_W < PWR_W + 20 || ACC_W > 48)
      $error("energy_pulse_output: unsupported widths");
  end

  // ------------------------------------------------------------
  // Select pins
  // ------------------------------------------------------------
  sel_code_t sel_code;

  pin_sync #(
    .WIDTH (3)
  ) u_sel_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin    ({calib_scale_select, freq_select_hi, freq_select_lo}),
    .level  (sel_code)
  );

  function automatic base_chz_t base_chz(input sel_code_t code);
    case (code)
      3'h0:    base_chz = `BASE_CHZ_0;
      3'h1:    base_chz = `BASE_CHZ_1;
      3'h2:    base_chz = `BASE_CHZ_2;
      3'h3:    base_chz = `BASE_CHZ_3;
      3'h4:    base_chz = `BASE_CHZ_4;
      3'h5:    base_chz = `BASE_CHZ_5;
      3'h6:    base_chz = `BASE_CHZ_6;
      default: base_chz = `BASE_CHZ_7;
    endcase
  endfunction

  function automatic cf_ratio_t cf_ratio(input sel_code_t code);
    case (code)
      3'h0:    cf_ratio = `CF_RATIO_0;
      3'h1:    cf_ratio = `CF_RATIO_1;
      3'h2:    cf_ratio = `CF_RATIO_2;
      3'h3:    cf_ratio = `CF_RATIO_3;
      3'h4:    cf_ratio = `CF_RATIO_4;
      3'h5:    cf_ratio = `CF_RATIO_5;
      3'h6:    cf_ratio = `CF_RATIO_6;
      default: cf_ratio = `CF_RATIO_7;
    endcase
  endfunction

  wire base_chz_t sel_base  = base_chz(sel_code);
  wire cf_ratio_t sel_ratio = cf_ratio(sel_code);

  // ------------------------------------------------------------
  // Magnitude, sign and no-load check
  // ------------------------------------------------------------
  localparam logic [PWR_W:0] FULL_SCALE = {2'b00, {(PWR_W-1){1'b1}}};
  localparam logic [PWR_W:0] CREEP_THR  =
    (PWR_W+1)'((64'(FULL_SCALE) * `CREEP_PPM) / `PPM_DIV);

  // Input is already the phase sum, so one threshold covers every phase
  wire                 sample_neg = power_sample[PWR_W-1];
  wire [PWR_W:0]       sample_ext = {power_sample[PWR_W-1], power_sample};
  wire [PWR_W:0]       magnitude  = sample_neg ? (PWR_W+1)'(-sample_ext) : sample_ext;
  wire                 above_thr  = magnitude >= CREEP_THR;
  wire                 accept     = power_valid && above_thr;

  // ------------------------------------------------------------
  // Energy accumulator feeding the calibration rate
  // ------------------------------------------------------------
  localparam logic [ACC_W-1:0] QUANTUM = ACC_W'(CF_QUANTUM);

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;

  // Rate scales with base frequency and the calibration multiple;
  // a single sample larger than the quantum only fires once per cycle
  wire [ACC_W-1:0] increment = ACC_W'(magnitude) * ACC_W'(sel_base) * ACC_W'(sel_ratio);
  wire [ACC_W-1:0] acc_sum   = acc_q + (accept ? increment : '0);
  wire             cf_fire   = acc_sum >= QUANTUM;
  assign acc_d = cf_fire ? acc_sum - QUANTUM : acc_sum;

  // ------------------------------------------------------------
  // Low-frequency divider and alternation
  // ------------------------------------------------------------
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic       use_b_q;

  // Code change mid-count just shortens or stretches one interval
  wire div_wrap = div_q >= sel_ratio - 8'd1;
  wire lf_fire  = cf_fire && div_wrap;
  assign div_d  = cf_fire ? (div_wrap ? 8'd0 : div_q + 8'd1) : div_q;

  // ------------------------------------------------------------
  // Reverse power
  // ------------------------------------------------------------
  logic neg_q;
  logic rev_q;

  wire neg_d = accept ? sample_neg : neg_q;
  wire rev_d = cf_fire ? neg_d : rev_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q   <= '0;
      div_q   <= 8'd0;
      use_b_q <= 1'b0;
      neg_q   <= 1'b0;
      rev_q   <= 1'b0;
    end else begin
      acc_q   <= acc_d;
      div_q   <= div_d;
      use_b_q <= lf_fire ? ~use_b_q : use_b_q;
      neg_q   <= neg_d;
      rev_q   <= rev_d;
    end
  end

  // ------------------------------------------------------------
  // Pulse shaping
  // ------------------------------------------------------------
  pulse_if pa_if ();
  pulse_if pb_if ();
  pulse_if cf_if ();

  assign pa_if.fire = lf_fire && !use_b_q;
  assign pb_if.fire = lf_fire &&  use_b_q;
  assign cf_if.fire = cf_fire;

  pulse_shaper #(
    .WIDTH_CYC (LF_WIDTH_CYC),
    .LIMIT_CYC (LF_LIMIT_CYC),
    .CNT_W     (CNT_W)
  ) u_shape_a (
    .clk    (clk),
    .resetn (resetn),
    .pio    (pa_if)
  );

  pulse_shaper #(
    .WIDTH_CYC (LF_WIDTH_CYC),
    .LIMIT_CYC (LF_LIMIT_CYC),
    .CNT_W     (CNT_W)
  ) u_shape_b (
    .clk    (clk),
    .resetn (resetn),
    .pio    (pb_if)
  );

  pulse_shaper #(
    .WIDTH_CYC (CF_WIDTH_CYC),
    .LIMIT_CYC (CF_LIMIT_CYC),
    .CNT_W     (CNT_W)
  ) u_shape_cf (
    .clk    (clk),
    .resetn (resetn),
    .pio    (cf_if)
  );

  assign energy_pulse_a     = pa_if.level;
  assign energy_pulse_b     = pb_if.level;
  assign calibration_pulse  = cf_if.level;
  assign reverse_power_flag = rev_q;
endmodule

// ### verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  logic             clk,
  input  logic             resetn,
  input  logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  initial begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic meta_q;
      logic stable_q;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          meta_q   <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q   <= pin[i];
          stable_q <= meta_q;
        end
      end
      assign level[i] = stable_q;
    end
  endgenerate
endmodule

// ### verilog/pulse_shaper.sv
`timescale 1ns/1ps
module pulse_shaper
  import meter_pkg::*;
#(
  parameter int WIDTH_CYC = 1000,
  parameter int LIMIT_CYC = 2000,
  parameter int CNT_W     = 28
) (
  input  logic     clk,
  input  logic     resetn,
  pulse_if.shaper  pio
);
  initial begin
    if (WIDTH_CYC < 1 || LIMIT_CYC < 2 || LIMIT_CYC >= (2 ** (CNT_W - 1)) || WIDTH_CYC >= (2 ** (CNT_W - 1)))
      $error("pulse_shaper: counts do not fit");
  end

  localparam logic [CNT_W-1:0] SAT   = '1;
  localparam logic [CNT_W-1:0] WIDTH = CNT_W'(WIDTH_CYC);
  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(LIMIT_CYC);

  shape_state_t     state_q, state_d;
  logic [CNT_W-1:0] since_q, since_d;
  logic [CNT_W-1:0] remain_q, remain_d;
  logic             level_q;

  // Period measured between fires; saturates so idle stretches read as long
  wire [CNT_W-1:0] period    = (since_q == SAT) ? SAT : since_q + 1'b1;
  wire [CNT_W-1:0] half      = (period >> 1) == '0 ? CNT_W'(1) : (period >> 1);
  wire             short_per = period < LIMIT;
  wire [CNT_W-1:0] width_sel = short_per ? half : WIDTH;

  assign since_d = pio.fire ? '0 : ((since_q == SAT) ? SAT : since_q + 1'b1);

  always_comb begin
    state_d  = state_q;
    remain_d = remain_q;
    case (state_q)
      SHAPE_IDLE: begin
        if (pio.fire) begin
          state_d  = SHAPE_HIGH;
          remain_d = width_sel - 1'b1;
        end
      end
      SHAPE_HIGH: begin
        if (pio.fire) begin
          remain_d = width_sel - 1'b1;
        end else if (remain_q == '0) begin
          state_d = SHAPE_IDLE;
        end else begin
          remain_d = remain_q - 1'b1;
        end
      end
      default: begin
        state_d  = SHAPE_IDLE;
        remain_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= SHAPE_IDLE;
      since_q  <= '1;
      remain_q <= '0;
      level_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      since_q  <= since_d;
      remain_q <= remain_d;
      level_q  <= (state_d == SHAPE_HIGH);
    end
  end

  assign pio.level = level_q;
endmodule
